// file: shared/watchdog_defines.svh
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH

// Register offsets on the plain register port.
`define ADDR_CONTROL 4'h0
`define ADDR_RELOAD 4'h1
`define ADDR_FEED_FIRST 4'h2
`define ADDR_FEED_SECOND 4'h3
`define ADDR_MODE 4'h4
`define ADDR_COUNT 4'h5

// Control register field positions.
`define BIT_CLKSEL 0
`define BIT_TOF 1
`define BIT_RUN 2
`define BIT_PRE_LO 5
`define BIT_PRE_HI 7

// Mode register field positions.
`define BIT_RSTEN 0
`define BIT_IRQEN 1
`define BIT_PWRDN 2

// Reset values.
`define CONTROL_RESET 8'he5
`define RELOAD_RESET 8'hff
`define MODE_RESET 8'h00

// Feed sequence bytes.
`define FEED_BYTE_FIRST 8'ha5
`define FEED_BYTE_SECOND 8'h5a

// Base exponent of the prescaler tap.
`define PRE_BASE 5

// Synchroniser depth of the clock switch.
`define SWITCH_CYCLES 2'd2

`endif

// file: shared/watchdog_pkg.sv
package watchdog_pkg;

  // Phases of a count clock switch-over.
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_RELEASE,
    SW_ACQUIRE
  } switch_state_type;

  // Tracks the two-write feed sequence.
  typedef enum logic [0:0] {
    FEED_WAIT_FIRST,
    FEED_WAIT_SECOND
  } feed_state_type;

endpackage : watchdog_pkg

// file: rtl/watchdog_unit.sv
// The implementer's own choices: the register addresses and the strobed register port.
`include "watchdog_defines.svh"

module watchdog_unit
  import watchdog_pkg::*;
#(
  parameter int PRE_WIDTH = 18
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic oscTick,
  output logic oscEnable,
  output logic chipReset,
  output logic irqRequest,
  output logic wakeUp
);
  import watchdog_pkg::*;

  // Two-flop synchroniser of the oscillator tick input.
  logic oscSync1_reg;
  logic oscSync2_reg;
  // Previous synchronised level, for edge detection.
  logic oscPrev_reg;
  // Core clock divider for the peripheral clock enable.
  logic pclkDiv_reg, pclkDiv_next;
  // Software-visible control, reload and mode registers.
  logic [7:0] control_reg, control_next;
  logic [7:0] reload_reg, reload_next;
  logic [7:0] mode_reg, mode_next;
  // Active shadow control register.
  logic [7:0] shadow_reg, shadow_next;
  // Active clock source, 1 is oscillator.
  logic activeSel_reg, activeSel_next;
  // Pending target clock source during a switch.
  logic targetSel_reg, targetSel_next;
  // Switch-over phase and its cycle counter.
  switch_state_type swState_reg, swState_next;
  logic [1:0] swCount_reg, swCount_next;
  // Feed sequence state.
  feed_state_type feedState_reg, feedState_next;
  // Prescaler and down counter.
  logic [PRE_WIDTH-1:0] prescale_reg, prescale_next;
  logic [7:0] counter_reg, counter_next;
  // Timer mode delayed control copy is pending.
  logic copyPending_reg, copyPending_next;
  // Counter has run out; the next tick is the underflow itself, which
  // gives the one extra tick of the timeout length.
  logic lastTick_reg, lastTick_next;
  // Registered outputs.
  logic [7:0] readData_next;
  logic chipReset_next, irqRequest_next, wakeUp_next, oscEnable_next;

  // Internal strobes.
  logic oscEdge, pclkEdge, oldEdge, newEdge, wdTick;
  logic feedDone, feedBad, underflow, timerMode, powerDown;

  // Last prescaler value for a tap: 2^(5+tap)-1.
  function automatic logic [PRE_WIDTH-1:0] pre_limit(input logic [2:0] tap);
    logic [PRE_WIDTH-1:0] one;
    one = {{(PRE_WIDTH-1){1'b0}}, 1'b1};
    pre_limit = (one << (`PRE_BASE + tap)) - one;
  endfunction : pre_limit

  // Synchroniser for the oscillator tick, which comes from another domain.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      oscSync1_reg <= 1'b0;
      oscSync2_reg <= 1'b0;
      oscPrev_reg <= 1'b0;
    end else begin
      oscSync1_reg <= oscTick;
      oscSync2_reg <= oscSync1_reg;
      oscPrev_reg <= oscSync2_reg;
    end
  end

  // Decode edges and mode bits.
  always_comb begin
    timerMode = !mode_reg[`BIT_RSTEN];
    powerDown = mode_reg[`BIT_PWRDN];
    oscEdge = oscSync2_reg && !oscPrev_reg;
    // Peripheral clock halts in power-down.
    pclkEdge = pclkDiv_reg && !powerDown;
    oldEdge = activeSel_reg ? oscEdge : pclkEdge;
    newEdge = targetSel_reg ? oscEdge : pclkEdge;
    // The counter only ticks while the clock selection is settled.
    wdTick = (swState_reg == SW_IDLE) && oldEdge && shadow_reg[`BIT_RUN];
    feedDone = regWrite && (regAddr == `ADDR_FEED_SECOND)
      && (regWriteData == `FEED_BYTE_SECOND)
      && (feedState_reg == FEED_WAIT_SECOND);
    feedBad = regWrite && (feedState_reg == FEED_WAIT_SECOND) && !feedDone;
    // Underflow is the tick after the counter and prescaler ran out.
    underflow = wdTick && lastTick_reg;
  end

  // Next-state logic for the whole watchdog.
  always_comb begin
    pclkDiv_next = !pclkDiv_reg;
    control_next = control_reg;
    reload_next = reload_reg;
    mode_next = mode_reg;
    shadow_next = shadow_reg;
    activeSel_next = activeSel_reg;
    targetSel_next = targetSel_reg;
    swState_next = swState_reg;
    swCount_next = swCount_reg;
    feedState_next = feedState_reg;
    prescale_next = prescale_reg;
    counter_next = counter_reg;
    copyPending_next = copyPending_reg;
    lastTick_next = lastTick_reg;
    readData_next = 8'h00;
    chipReset_next = 1'b0;
    irqRequest_next = 1'b0;
    wakeUp_next = 1'b0;
    // Register writes.
    if (regWrite) begin
      case (regAddr)
        `ADDR_CONTROL: begin
          control_next = regWriteData;
          control_next[4:3] = 2'b00;
          // Flag is kept unless software writes zero.
          control_next[`BIT_TOF] = control_reg[`BIT_TOF]
            && regWriteData[`BIT_TOF];
          copyPending_next = 1'b1;
        end
        `ADDR_RELOAD: reload_next = regWriteData;
        `ADDR_MODE: mode_next = regWriteData;
        default: begin
        end
      endcase
    end
    // Feed sequence tracking.
    if (regWrite && regAddr == `ADDR_FEED_FIRST
        && regWriteData == `FEED_BYTE_FIRST) begin
      feedState_next = FEED_WAIT_SECOND;
    end else if (regWrite) begin
      feedState_next = FEED_WAIT_FIRST;
    end
    // Wrong feed resets in watchdog mode, ignored in timer mode.
    if (feedBad && !timerMode) begin
      chipReset_next = 1'b1;
    end
    // Timer mode: delayed copy of the control register.
    // The copy follows any edge of the source, so a stopped timer can
    // still be started again by setting its run bit.
    if (timerMode && copyPending_reg && oldEdge) begin
      shadow_next = control_reg;
      copyPending_next = 1'b0;
    end
    // Completed feed loads shadow and counter and restarts prescaler.
    if (feedDone) begin
      shadow_next = control_reg;
      counter_next = reload_reg;
      prescale_next = '0;
      copyPending_next = 1'b0;
      lastTick_next = 1'b0;
      // Clock select only changes here.
      if (control_reg[`BIT_CLKSEL] != activeSel_reg) begin
        targetSel_next = control_reg[`BIT_CLKSEL];
        swState_next = SW_RELEASE;
        swCount_next = 2'd0;
      end
      if (!timerMode) begin
        control_next[`BIT_TOF] = 1'b0;
      end
    end else if (wdTick) begin
      if (lastTick_reg) begin
        // Underflow tick: reload and start the next period at once.
        lastTick_next = 1'b0;
        prescale_next = '0;
        counter_next = reload_reg;
      end else if (prescale_reg
          == pre_limit(shadow_reg[`BIT_PRE_HI:`BIT_PRE_LO])) begin
        prescale_next = '0;
        if (counter_reg == 8'h00) begin
          // Hold at zero for the final tick of the timeout.
          lastTick_next = 1'b1;
        end else begin
          counter_next = counter_reg - 8'h01;
        end
      end else begin
        prescale_next = prescale_reg + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
      end
    end
    // Switch-over: wait two old edges, then two new edges.
    // A stopped old clock stalls the switch here.
    case (swState_reg)
      SW_IDLE: begin
      end
      SW_RELEASE: begin
        if (oldEdge) begin
          swCount_next = swCount_reg + 2'd1;
          if (swCount_reg + 2'd1 == `SWITCH_CYCLES) begin
            swState_next = SW_ACQUIRE;
            swCount_next = 2'd0;
          end
        end
      end
      SW_ACQUIRE: begin
        if (newEdge) begin
          swCount_next = swCount_reg + 2'd1;
          if (swCount_reg + 2'd1 == `SWITCH_CYCLES) begin
            swState_next = SW_IDLE;
            activeSel_next = targetSel_reg;
            swCount_next = 2'd0;
          end
        end
      end
      default: swState_next = SW_IDLE;
    endcase
    // Underflow sets the flag, the set wins over a clear.
    if (underflow) begin
      control_next[`BIT_TOF] = 1'b1;
      irqRequest_next = timerMode && mode_reg[`BIT_IRQEN];
      wakeUp_next = powerDown;
      if (!timerMode) begin
        chipReset_next = 1'b1;
      end
    end
    // Oscillator runs in power-down only while active or the target of a switch.
    oscEnable_next = !powerDown || activeSel_reg
      || (swState_reg != SW_IDLE && targetSel_reg);
    // Read data, one cycle after the strobe.
    if (regRead) begin
      case (regAddr)
        `ADDR_CONTROL: readData_next = control_reg;
        `ADDR_RELOAD: readData_next = reload_reg;
        `ADDR_MODE: readData_next = mode_reg;
        `ADDR_COUNT: readData_next = counter_reg;
        default: readData_next = 8'h00;
      endcase
    end
  end

  // Register every piece of state except the oscillator synchroniser flops.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pclkDiv_reg <= 1'b0;
      control_reg <= `CONTROL_RESET;
      reload_reg <= `RELOAD_RESET;
      mode_reg <= `MODE_RESET;
      shadow_reg <= `CONTROL_RESET;
      activeSel_reg <= 1'b1;
      targetSel_reg <= 1'b1;
      swState_reg <= SW_IDLE;
      swCount_reg <= 2'd0;
      feedState_reg <= FEED_WAIT_FIRST;
      prescale_reg <= '0;
      counter_reg <= `RELOAD_RESET;
      copyPending_reg <= 1'b0;
      lastTick_reg <= 1'b0;
      regReadData <= 8'h00;
      chipReset <= 1'b0;
      irqRequest <= 1'b0;
      wakeUp <= 1'b0;
      oscEnable <= 1'b1;
    end else begin
      pclkDiv_reg <= pclkDiv_next;
      control_reg <= control_next;
      reload_reg <= reload_next;
      mode_reg <= mode_next;
      shadow_reg <= shadow_next;
      activeSel_reg <= activeSel_next;
      targetSel_reg <= targetSel_next;
      swState_reg <= swState_next;
      swCount_reg <= swCount_next;
      feedState_reg <= feedState_next;
      prescale_reg <= prescale_next;
      counter_reg <= counter_next;
      copyPending_reg <= copyPending_next;
      lastTick_reg <= lastTick_next;
      regReadData <= readData_next;
      chipReset <= chipReset_next;
      irqRequest <= irqRequest_next;
      wakeUp <= wakeUp_next;
      oscEnable <= oscEnable_next;
    end
  end

endmodule : watchdog_unit

// file: test/watchdog_unit_props.sv
`include "watchdog_defines.svh"

// Watches the watchdog ports and flags protocol and pulse slips.
module watchdog_unit_props #(
  parameter int PRE_WIDTH = 18
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic oscTick,
  input wire logic oscEnable,
  input wire logic chipReset,
  input wire logic irqRequest,
  input wire logic wakeUp
);
  logic [2:0] modeReg; // Last mode value written by software.
  logic [2:0] modeNext; // Next value of the mode copy.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Follows writes to the mode register.
  always_comb begin
    modeNext = modeReg;
    if (regWrite && regAddr == `ADDR_MODE) begin
      modeNext = regWriteData[2:0];
    end
  end

  // Registers the mode copy.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      modeReg <= 3'h0;
    end else begin
      modeReg <= modeNext;
    end
  end

  // First half of a feed.
  sequence feedFirst;
    regWrite && regAddr == `ADDR_FEED_FIRST
      && regWriteData == `FEED_BYTE_FIRST;
  endsequence

  // Any write other than the second half of a feed.
  sequence wrongWrite;
    regWrite && !(regAddr == `ADDR_FEED_SECOND
      && regWriteData == `FEED_BYTE_SECOND);
  endsequence

  read_idle_zero_a: assert property (
    !$past(regRead) |-> regReadData == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (
    regRead && regAddr > `ADDR_COUNT |=> regReadData == 8'h00)
    else $error("unmapped read returned data");
  reserved_bits_a: assert property (
    regRead && regAddr == `ADDR_CONTROL |=> regReadData[4:3] == 2'b00)
    else $error("reserved control bits read nonzero");
  reload_readback_a: assert property (
    regWrite && regAddr == `ADDR_RELOAD ##1 regRead
      && regAddr == `ADDR_RELOAD |=> regReadData == $past(regWriteData, 2))
    else $error("reload readback mismatch");
  bad_feed_reset_a: assert property (
    feedFirst ##1 (wrongWrite and modeReg[0]) |=> chipReset)
    else $error("bad feed gave no reset pulse");
  reset_mode_only_a: assert property (
    chipReset |-> modeReg[0])
    else $error("reset pulse in timer mode");
  irq_enabled_only_a: assert property (
    irqRequest |-> modeReg[1] && !modeReg[0])
    else $error("interrupt while not enabled");
  irq_single_pulse_a: assert property (
    irqRequest |=> !irqRequest [*8])
    else $error("interrupt pulses too close");
  wake_in_powerdown_a: assert property (
    wakeUp |-> modeReg[2])
    else $error("wake pulse outside power-down");
  wake_single_a: assert property (
    $rose(wakeUp) |=> $fell(wakeUp))
    else $error("wake pulse longer than one cycle");
endmodule : watchdog_unit_props

bind watchdog_unit watchdog_unit_props #(.PRE_WIDTH(PRE_WIDTH)) props (
  .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
  .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .oscTick(oscTick), .oscEnable(oscEnable),
  .chipReset(chipReset), .irqRequest(irqRequest), .wakeUp(wakeUp)
);

// file: test/watchdog_unit_test.sv
`include "watchdog_defines.svh"

// Drives the watchdog through its register port and checks its pulses.
module watchdog_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, resetn, regWrite, regRead, oscTick;
  logic [3:0] regAddr;
  logic [7:0] regWriteData, regReadData, d, e;
  logic oscEnable, chipReset, irqRequest, wakeUp;
  int errors = 0;
  int comparisons = 0;
  int n;

  watchdog_unit uut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .oscTick(oscTick), .oscEnable(oscEnable),
    .chipReset(chipReset), .irqRequest(irqRequest), .wakeUp(wakeUp));

  // Core clock, 5 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Oscillator stand-in, sped up to 16 core cycles a period.
  initial begin
    oscTick = 1'b0;
    #2;
    forever #40 oscTick = ~oscTick;
  end

  // Cuts a hang short.
  initial begin
    #100us;
    errors++;
    report_and_stop();
  end

  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkByte

  task automatic checkCount(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      errors++;
      $display("CHECK FAILED at %0t: count %0d not in %0d..%0d", $time, got,
        lo, hi);
    end
  endtask : checkCount

  // One write cycle; the strobe stays up until a later rd or idle call drops it.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regRead <= 1'b0;
    regAddr <= a;
    regWriteData <= v;
  endtask : wr

  // One read cycle; data are taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regWrite <= 1'b0;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    v = regReadData;
  endtask : rd

  task automatic idle(input int cycles);
    repeat (cycles) begin
      @(posedge sys_clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
    end
  endtask : idle

  task automatic feed();
    wr(`ADDR_FEED_FIRST, `FEED_BYTE_FIRST);
    wr(`ADDR_FEED_SECOND, `FEED_BYTE_SECOND);
    idle(1);
  endtask : feed

  // Counts cycles until irq (0), wake (1) or reset (2) pulses.
  task automatic waitFor(input int which, input int limit, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < limit) begin
      @(posedge sys_clk);
      cnt++;
      hit = (which == 0) ? irqRequest === 1'b1 :
        (which == 1) ? wakeUp === 1'b1 : chipReset === 1'b1;
    end
  endtask : waitFor

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence of tests.
  initial begin
    resetn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWriteData = 8'h00;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`ADDR_CONTROL, d); checkByte(d, `CONTROL_RESET);
    rd(`ADDR_RELOAD, d); checkByte(d, `RELOAD_RESET);
    rd(`ADDR_MODE, d); checkByte(d, `MODE_RESET);
    rd(4'h7, d); checkByte(d, 8'h00);
    $display("test reset values done");
    // Periodic interrupt from the halved core clock, four counts a period.
    wr(`ADDR_MODE, 8'h02);
    wr(`ADDR_RELOAD, 8'h03);
    rd(`ADDR_RELOAD, d); checkByte(d, 8'h03);
    wr(`ADDR_CONTROL, 8'h04);
    feed();
    waitFor(0, 600, n); checkCount(n, 256, 340);
    // A period is 129 ticks of the halved core clock.
    waitFor(0, 600, n); checkCount(n, 258, 258);
    rd(`ADDR_CONTROL, d); checkByte(d, 8'h06);
    wr(`ADDR_CONTROL, 8'h04);
    rd(`ADDR_CONTROL, d); checkByte(d, 8'h04);
    $display("test peripheral timer done");
    // A broken feed in timer mode gives no reset.
    wr(`ADDR_FEED_FIRST, `FEED_BYTE_FIRST);
    wr(`ADDR_RELOAD, 8'h03);
    idle(1);
    waitFor(2, 20, n); checkCount(n, 20, 20);
    // Power-down with the peripheral clock freezes the counter.
    wr(`ADDR_MODE, 8'h06);
    idle(4);
    checkByte({7'h00, oscEnable}, 8'h00);
    rd(`ADDR_COUNT, d);
    idle(150);
    rd(`ADDR_COUNT, e); checkByte(e, d);
    $display("test power-down stop done");
    // Oscillator source wakes the device periodically.
    wr(`ADDR_MODE, 8'h02);
    wr(`ADDR_CONTROL, 8'h05);
    feed();
    // The old clock runs far longer than four core cycles before sleep.
    idle(100);
    wr(`ADDR_MODE, 8'h06);
    idle(2);
    checkByte({7'h00, oscEnable}, 8'h01);
    waitFor(1, 3000, n); checkCount(n, 1, 2999);
    // A period is 129 oscillator ticks of 16 core cycles each.
    waitFor(1, 3000, n); checkCount(n, 2064, 2064);
    $display("test oscillator wake done");
    // A good feed in watchdog mode clears the flag; a broken one resets.
    wr(`ADDR_MODE, 8'h01);
    feed();
    rd(`ADDR_CONTROL, d); checkByte(d, 8'h05);
    wr(`ADDR_FEED_FIRST, `FEED_BYTE_FIRST);
    wr(`ADDR_CONTROL, 8'h05);
    idle(1);
    waitFor(2, 4, n); checkCount(n, 1, 3);
    $display("test watchdog bad feed done");
    report_and_stop();
  end
endmodule : watchdog_unit_test
